// *** rtl/srr_readout.sv ***
// Status byte and read-frame generator with SPI link and AHB-Lite config
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "srr_defines.svh"

module srr_readout (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // SPI link, mode 3
  input  wire logic        CSN,
  input  wire logic        SCK,
  input  wire logic        SDI,
  output logic             SDO,
  output logic             SDO_OE,
  // Press output or trigger input pin
  input  wire logic        PRESS_TRIG_I,
  output logic             PRESS_TRIG_O,
  output logic             PRESS_TRIG_OE,
  // Measurement engine
  output srr_pkg::srr_mode_t MEAS_MODE,
  output logic      [3:0]  MEAS_GATE,
  output logic             MEAS_START,
  output logic             ANGLE_PLANE,
  input  wire logic        MEAS_DONE,
  input  wire logic        WAKE_CHANGE,
  input  wire logic [15:0] MEAS_TEMP,
  input  wire logic [15:0] MEAS_X,
  input  wire logic [15:0] MEAS_Y,
  input  wire logic [15:0] MEAS_Z,
  input  wire logic [15:0] MEAS_ANGLE,
  input  wire logic [15:0] MEAS_MAG,
  input  wire logic [15:0] PLANE_FIELD,
  input  wire logic [15:0] PRESENT_FIELD
);
  import srr_pkg::*;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  srr_mode_t   mode_r, mode_nxt;
  logic [3:0]  cfg_r;
  logic [15:0] press_cfg_r;
  logic [31:0] hrdata_r;
  logic        wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [2:0]  csn_s, sck_s, trig_s;
  logic [1:0]  sdi_s;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  cmd_r;
  logic [71:0] tx_r, frame_r;
  logic        load_pend_r, tx_en_r, read_pend_r;
  logic [3:0]  gate_r;
  logic [7:0]  status_r, status_nxt;
  logic        fresh_r, reset_done_r, press_r, over_r, start_r;
  logic        sck_rise, sck_fall, csn_rise, cmd_done;
  logic [7:0]  cmd_byte;
  logic        is_meas, is_reg, is_read, is_reset, cmd_err;
  logic        trig_start;
  logic        addr_ph;
  logic [63:0] words;

  // Bus slave never stalls and never errors
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_r;
  assign addr_ph   = HSEL && HREADY && HTRANS[1];

  // Read data prepared in the address phase so it stands in the data phase
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_ph && !HWRITE) begin
      unique case (HADDR[11:0])
        `SRR_ADDR_CFG:    hrdata_r <= {28'h000_0000, cfg_r};
        `SRR_ADDR_PRESS:  hrdata_r <= {16'h0000, press_cfg_r};
        `SRR_ADDR_STATUS: hrdata_r <= {22'h00_0000, mode_r, status_nxt};
        default:          hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Write address held over into the data phase
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_ph && HWRITE;
      wr_addr_r <= HADDR[11:0];
    end
  end

  // Configuration registers; unmapped writes are dropped
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      cfg_r       <= `SRR_CFG_RST;
      press_cfg_r <= `SRR_PRESS_RST;
    end else if (wr_pend_r) begin
      if (wr_addr_r == `SRR_ADDR_CFG)
        cfg_r <= HWDATA[3:0];
      if (wr_addr_r == `SRR_ADDR_PRESS)
        press_cfg_r <= HWDATA[15:0];
    end
  end

  assign ANGLE_PLANE = cfg_r[`SRR_CFG_PLANESEL];

  // Two-flop synchronisers; edges taken from stages two and three only
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      csn_s  <= 3'h7;
      sck_s  <= 3'h7;
      sdi_s  <= 2'h0;
      trig_s <= 3'h0;
    end else begin
      csn_s  <= {csn_s[1:0], CSN};
      sck_s  <= {sck_s[1:0], SCK};
      sdi_s  <= {sdi_s[0], SDI};
      trig_s <= {trig_s[1:0], PRESS_TRIG_I};
    end
  end

  assign sck_rise = !csn_s[1] && sck_s[1] && !sck_s[2];
  assign sck_fall = !csn_s[1] && !sck_s[1] && sck_s[2];
  assign csn_rise = csn_s[1] && !csn_s[2];
  assign cmd_done = sck_rise && (bit_cnt_r == 4'h7);
  assign cmd_byte = {cmd_r[6:0], sdi_s[1]};

  // Command bits counted on rising SCK, later bits ignored
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      bit_cnt_r <= 4'h0;
      cmd_r     <= 8'h00;
    end else if (csn_s[1]) begin
      bit_cnt_r <= 4'h0;
    end else if (sck_rise && bit_cnt_r != 4'h8) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      cmd_r     <= cmd_byte;
    end
  end

  // Command decode from the byte as it completes
  always_comb begin
    is_meas  = cmd_byte[7:4] == `SRR_CMD_CONT ||
               cmd_byte[7:4] == `SRR_CMD_WAKE ||
               cmd_byte[7:4] == `SRR_CMD_SINGLE;
    is_reg   = cmd_byte[7:4] == `SRR_CMD_RDREG ||
               cmd_byte[7:4] == `SRR_CMD_WRREG;
    is_read  = cmd_byte[7:4] == `SRR_CMD_READ;
    is_reset = cmd_byte[7:4] == `SRR_CMD_RESET;
    cmd_err  = (is_meas && mode_r != SRR_IDLE) ||
               (is_reg && mode_r == SRR_CONT);
  end

  // Trigger pulse only counts while the pin is an input and idle
  assign trig_start = !cfg_r[`SRR_CFG_PINSEL] && trig_s[1] && !trig_s[2] &&
                      mode_r == SRR_IDLE && !cmd_done;

  // Mode after this cycle's command or completion
  always_comb begin
    mode_nxt = mode_r;
    if (cmd_done && is_reset) begin
      mode_nxt = SRR_IDLE;
    end else if (cmd_done && cmd_byte[7:4] == `SRR_CMD_IDLE) begin
      mode_nxt = SRR_IDLE;
    end else if (cmd_done && is_meas && mode_r == SRR_IDLE) begin
      mode_nxt = srr_mode_t'(cmd_byte[5:4]);
    end else if (trig_start) begin
      mode_nxt = SRR_SINGLE;
    end else if (mode_r == SRR_SINGLE && MEAS_DONE) begin
      mode_nxt = SRR_IDLE;
    end
  end

  // Status as answered for the command now completing
  always_comb begin
    status_nxt = 8'h00;
    status_nxt[`SRR_ST_CONT]    = mode_nxt == SRR_CONT;
    status_nxt[`SRR_ST_WAKE]    = mode_nxt == SRR_WAKE;
    status_nxt[`SRR_ST_SINGLE]  = mode_nxt == SRR_SINGLE;
    status_nxt[`SRR_ST_ERR]     = cmd_done && cmd_err;
    status_nxt[`SRR_ST_PRESS]   = press_r;
    status_nxt[`SRR_ST_OVER]    = over_r;
    status_nxt[`SRR_ST_RSTDONE] = reset_done_r;
    status_nxt[`SRR_ST_FRESH]   = fresh_r;
  end

  // Mode, item gate and start pulse toward the engine
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      mode_r  <= SRR_IDLE;
      gate_r  <= 4'h0;
      start_r <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      start_r <= (cmd_done && is_meas && mode_r == SRR_IDLE) || trig_start;
      if (cmd_done && is_meas && mode_r == SRR_IDLE)
        gate_r <= cmd_byte[3:0];
      else if (cmd_done && is_reset)
        gate_r <= 4'h0;
    end
  end

  assign MEAS_MODE  = mode_r;
  assign MEAS_GATE  = gate_r;
  assign MEAS_START = start_r;

  // Reset-done shown once; a reset command re-arms it
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN)
      reset_done_r <= 1'b0;
    else if (cmd_done)
      reset_done_r <= is_reset;
  end

  // Fresh flag: new data wins over a read finishing in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN)
      fresh_r <= 1'b0;
    else if (MEAS_DONE && (mode_r == SRR_CONT || mode_r == SRR_SINGLE))
      fresh_r <= 1'b1;
    else if (WAKE_CHANGE && mode_r == SRR_WAKE)
      fresh_r <= 1'b1;
    else if (csn_rise && read_pend_r)
      fresh_r <= 1'b0;
  end

  // Threshold flags refreshed at every completed measurement
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      press_r <= 1'b0;
      over_r  <= 1'b0;
    end else if (MEAS_DONE) begin
      press_r <= cfg_r[`SRR_CFG_PINSEL] &&
                 PLANE_FIELD > {3'h0, press_cfg_r[12:0]};
      over_r  <= !cfg_r[`SRR_CFG_ABSEN] &&
                 PRESENT_FIELD > {press_cfg_r[15:13], 13'h0000};
    end
  end

  // Pin drives only in press mode; otherwise it is the trigger input
  assign PRESS_TRIG_OE = cfg_r[`SRR_CFG_PINSEL];
  assign PRESS_TRIG_O  = press_r && cfg_r[`SRR_CFG_PINSEL];

  // Words in T, X|A, Y|B, Z order; fields to offset form
  always_comb begin
    if (cfg_r[`SRR_CFG_FMTSEL])
      words = {MEAS_Z ^ `SRR_ZERO_FIELD, MEAS_MAG, MEAS_ANGLE,
               MEAS_TEMP};
    else
      words = {MEAS_Z ^ `SRR_ZERO_FIELD, MEAS_Y ^ `SRR_ZERO_FIELD,
               MEAS_X ^ `SRR_ZERO_FIELD, MEAS_TEMP};
  end

  // Packs status then gated words, high byte first, ungated skipped
  function automatic logic [71:0] pack_frame(input logic [7:0]  st,
                                             input logic [3:0]  gate,
                                             input logic [63:0] w);
    logic [71:0] f;
    integer      n;
    f = {st, 64'h0};
    n = 0;
    for (int i = 0; i < 4; i++) begin
      if (gate[i]) begin
        f[63 - 16 * n -: 16] = w[16 * i +: 16];
        n = n + 1;
      end
    end
    return f;
  endfunction

  // Frame captured as the command completes; reset gets no answer
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      frame_r     <= 72'h0;
      status_r    <= 8'h00;
      load_pend_r <= 1'b0;
      read_pend_r <= 1'b0;
    end else if (csn_s[1]) begin
      load_pend_r <= 1'b0;
      read_pend_r <= 1'b0;
    end else if (cmd_done) begin
      status_r    <= status_nxt;
      load_pend_r <= !is_reset;
      read_pend_r <= is_read;
      if (is_read)
        frame_r <= pack_frame(status_nxt, gate_r, words);
      else
        frame_r <= {status_nxt, 64'h0};
    end else if (sck_fall && load_pend_r) begin
      load_pend_r <= 1'b0;
    end
  end

  // Output shifter moves on falling SCK; zeros follow the frame
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tx_r    <= 72'h0;
      tx_en_r <= 1'b0;
    end else if (csn_s[1]) begin
      tx_en_r <= 1'b0;
    end else if (sck_fall && load_pend_r) begin
      tx_r    <= frame_r;
      tx_en_r <= 1'b1;
    end else if (sck_fall && tx_en_r) begin
      tx_r <= {tx_r[70:0], 1'b0};
    end
  end

  assign SDO    = tx_r[71];
  assign SDO_OE = tx_en_r && !csn_s[1];

  // Command byte completing, as seen by several checks
  sequence s_cmd(logic [3:0] op);
    cmd_done && cmd_byte[7:4] == op;
  endsequence

  a_cont_flag: assert property (
    s_cmd(`SRR_CMD_CONT) and mode_r == SRR_IDLE
      |=> status_r[`SRR_ST_CONT] && mode_r == SRR_CONT)
    else $error("continuous flag missing");
  a_wake_flag: assert property (
    s_cmd(`SRR_CMD_WAKE) and mode_r == SRR_IDLE
      |=> status_r[`SRR_ST_WAKE] && mode_r == SRR_WAKE)
    else $error("wake flag missing");
  a_single_end: assert property (
    mode_r == SRR_SINGLE && MEAS_DONE && !cmd_done
      |=> mode_r == SRR_IDLE && !status_nxt[`SRR_ST_SINGLE])
    else $error("single mode not left");
  a_meas_err: assert property (
    cmd_done && is_meas && mode_r != SRR_IDLE
      |=> status_r[`SRR_ST_ERR] && $stable(mode_r))
    else $error("measurement command in mode not flagged");
  a_reg_err: assert property (
    cmd_done && is_reg && mode_r == SRR_CONT |=> status_r[`SRR_ST_ERR])
    else $error("register access in continuous not flagged");
  a_press_pin: assert property (
    MEAS_DONE && cfg_r[`SRR_CFG_PINSEL] && !wr_pend_r &&
    PLANE_FIELD > {3'h0, press_cfg_r[12:0]}
      |=> PRESS_TRIG_O && PRESS_TRIG_OE)
    else $error("press pin not raised");
  a_over_flag: assert property (
    MEAS_DONE && !cfg_r[`SRR_CFG_ABSEN] &&
    PRESENT_FIELD > {press_cfg_r[15:13], 13'h0000} |=> over_r)
    else $error("over-limit flag not set");
  a_reset_arm: assert property (
    s_cmd(`SRR_CMD_RESET) |=> reset_done_r)
    else $error("reset-done not armed");
  a_reset_once: assert property (
    cmd_done && reset_done_r && !is_reset
      |=> status_r[`SRR_ST_RSTDONE] && !reset_done_r)
    else $error("reset-done not shown once");
  a_reset_quiet: assert property (
    s_cmd(`SRR_CMD_RESET) |=> !load_pend_r && !SDO_OE)
    else $error("reset command answered");
  a_fresh_set: assert property (
    MEAS_DONE && mode_r == SRR_CONT |=> fresh_r)
    else $error("fresh flag not set");
  a_fresh_clr: assert property (
    csn_rise && read_pend_r && !MEAS_DONE && !WAKE_CHANGE |=> !fresh_r)
    else $error("fresh flag not cleared by read");

endmodule

// *** rtl/srr_defines.svh ***
// Offsets, field positions, command codes and reset values for the readout
`ifndef SRR_DEFINES_SVH
`define SRR_DEFINES_SVH

// Register byte addresses on the AHB-Lite slave
`define SRR_ADDR_CFG      12'h000
`define SRR_ADDR_PRESS    12'h004
`define SRR_ADDR_STATUS   12'h008

// Configuration register field positions
`define SRR_CFG_PINSEL    0
`define SRR_CFG_ABSEN     1
`define SRR_CFG_FMTSEL    2
`define SRR_CFG_PLANESEL  3

// Reset values
`define SRR_CFG_RST       4'h0
`define SRR_PRESS_RST     16'h0000

// Status byte bit positions
`define SRR_ST_FRESH      0
`define SRR_ST_RSTDONE    1
`define SRR_ST_OVER       2
`define SRR_ST_PRESS      3
`define SRR_ST_ERR        4
`define SRR_ST_SINGLE     5
`define SRR_ST_WAKE       6
`define SRR_ST_CONT       7

// Command upper nibbles
`define SRR_CMD_CONT      4'h1
`define SRR_CMD_WAKE      4'h2
`define SRR_CMD_SINGLE    4'h3
`define SRR_CMD_READ      4'h4
`define SRR_CMD_RDREG     4'h5
`define SRR_CMD_WRREG     4'h6
`define SRR_CMD_IDLE      4'h8
`define SRR_CMD_RESET     4'hF

// Offset that maps a signed field to the unsigned output word
`define SRR_ZERO_FIELD    16'h8000

`endif

// *** rtl/srr_pkg.sv ***
// Types shared by the status and result readout
package srr_pkg;
  typedef enum logic [1:0] {
    SRR_IDLE   = 2'b00,
    SRR_CONT   = 2'b01,
    SRR_WAKE   = 2'b10,
    SRR_SINGLE = 2'b11
  } srr_mode_t;
endpackage

// *** tb/srr_host_model.sv ***
// SPI host model in mode 3 that sends commands and collects the answer frame
`timescale 1ns/1ps

module srr_host_model (
  // SPI pins
  output logic      CSN,
  output logic      SCK,
  output logic      SDI,
  input  wire logic SDO,
  input  wire logic SDO_OE
);
  // Clock stands high outside frames
  initial begin
    CSN = 1'h1;
    SCK = 1'h1;
    SDI = 1'h0;
  end

  // One command per chip-select period, answer bytes clocked after it
  task automatic xfer(input logic [7:0] cmd, input int nb,
                      output logic [71:0] rx);
    int i;
    rx = '0;
    // Edges kept off the system clock's rising edge
    #10;
    CSN = 1'h0;
    #160;
    for (i = 0; i < 8 + 8 * nb; i++) begin
      SCK = 1'h0;
      // Past the command the line toggles so nothing stale is seen
      SDI = (i < 8) ? cmd[7 - i] : ~SDI;
      #160;
      SCK = 1'h1;
      // An undriven data line gives an unknown bit
      if (i >= 8) begin
        rx = {rx[70:0], SDO_OE ? SDO : 1'hx};
      end
      #160;
    end
    CSN = 1'h1;
    #630;
  endtask
endmodule

// *** tb/status_and_result_readout_test.sv ***
// Self-checking bench for the status and result readout
`timescale 1ns/1ps
`include "srr_defines.svh"

module status_and_result_readout_test;
  import srr_pkg::*;

  typedef struct packed {
    logic [7:0] cmd;
    logic       done;
    logic       wake;
    logic [7:0] st;
  } srr_row_t;

  // Design inputs, all set at time zero
  logic        SYS_CLK = 1'h0;
  logic        rstn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic        press_i = 1'h0;
  logic        meas_done = 1'h0;
  logic        wake_change = 1'h0;
  logic [15:0] temp = 16'h1234;
  logic [15:0] x_f = 16'h0102;
  logic [15:0] y_f = 16'hFFFE;
  logic [15:0] z_f = 16'h0005;
  logic [15:0] ang = 16'h9030;
  logic [15:0] mag = 16'h4321;
  logic [15:0] plane = 16'h0011;
  logic [15:0] present = 16'h0000;
  // Design outputs and link wires
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        csn;
  logic        sck;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        press_o;
  logic        press_oe;
  srr_mode_t   mode;
  logic [3:0]  gate;
  logic        start;
  logic        aplane;
  logic [71:0] rx;
  logic [31:0] rd;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_start = 0;

  // Command sequence: pulses before the command, then expected status
  srr_row_t rows [17] = '{
    '{8'h80, 1'h0, 1'h0, 8'h00},
    '{8'h1F, 1'h0, 1'h0, 8'h80},
    '{8'h39, 1'h0, 1'h0, 8'h90},
    '{8'h50, 1'h0, 1'h0, 8'h90},
    '{8'h60, 1'h0, 1'h0, 8'h90},
    '{8'h40, 1'h1, 1'h0, 8'h81},
    '{8'h80, 1'h0, 1'h0, 8'h00},
    '{8'h2F, 1'h0, 1'h0, 8'h40},
    '{8'h40, 1'h0, 1'h1, 8'h41},
    '{8'h80, 1'h0, 1'h0, 8'h00},
    '{8'hF0, 1'h0, 1'h0, 8'hXX},
    '{8'h80, 1'h0, 1'h0, 8'h02},
    '{8'h80, 1'h0, 1'h0, 8'h00},
    '{8'h3F, 1'h0, 1'h0, 8'h20},
    '{8'h80, 1'h1, 1'h0, 8'h01},
    '{8'h40, 1'h0, 1'h0, 8'h01},
    '{8'h80, 1'h0, 1'h0, 8'h00}
  };

  always #20 SYS_CLK = ~SYS_CLK;

  // Engine start pulses, counted for the closing check
  always @(posedge SYS_CLK) if (start === 1'h1) n_start <= n_start + 1;

  srr_readout srr_readout_i (
    .SYS_CLK(SYS_CLK), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .CSN(csn), .SCK(sck), .SDI(sdi), .SDO(sdo),
    .SDO_OE(sdo_oe), .PRESS_TRIG_I(press_i), .PRESS_TRIG_O(press_o),
    .PRESS_TRIG_OE(press_oe), .MEAS_MODE(mode), .MEAS_GATE(gate),
    .MEAS_START(start), .ANGLE_PLANE(aplane), .MEAS_DONE(meas_done),
    .WAKE_CHANGE(wake_change), .MEAS_TEMP(temp), .MEAS_X(x_f),
    .MEAS_Y(y_f), .MEAS_Z(z_f), .MEAS_ANGLE(ang), .MEAS_MAG(mag),
    .PLANE_FIELD(plane), .PRESENT_FIELD(present)
  );

  srr_host_model srr_host_model_i (
    .CSN(csn), .SCK(sck), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe)
  );

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [71:0] seen,
                       input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single AHB transfer; waits on ready, no wait count assumed
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge SYS_CLK);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge SYS_CLK);
    while (hreadyout !== 1'h1) @(posedge SYS_CLK);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    @(posedge SYS_CLK);
    while (hreadyout !== 1'h1) @(posedge SYS_CLK);
    rd = hrdata;
  endtask

  // One-cycle engine pulse, completion or wake change
  task automatic pulse(input logic w);
    @(posedge SYS_CLK);
    meas_done <= ~w;
    wake_change <= w;
    @(posedge SYS_CLK);
    meas_done <= 1'h0;
    wake_change <= 1'h0;
    repeat (4) @(posedge SYS_CLK);
  endtask

  // Watchdog, well beyond the expected run of about 0.2 ms
  initial begin
    #3000000;
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge SYS_CLK);
    rstn <= 1'h1;
    repeat (4) @(posedge SYS_CLK);
    check("mode after reset", mode, SRR_IDLE);
    check("sdo_oe after reset", sdo_oe, 1'h0);
    check("pin oe after reset", press_oe, 1'h0);
    check("hresp after reset", hresp, 1'h0);
    ahb(1'h0, `SRR_ADDR_CFG, 32'h0);
    check("cfg reset", rd, `SRR_CFG_RST);
    ahb(1'h0, 32'h0000_0FF0, 32'h0);
    check("unmapped read", rd, 64'h0);
    foreach (rows[k]) begin
      if (rows[k].done) pulse(1'h0);
      if (rows[k].wake) pulse(1'h1);
      srr_host_model_i.xfer(rows[k].cmd, 1, rx);
      check("status", rx[7:0], rows[k].st);
    end
    // Axis frame with press and over-limit just past their thresholds
    ahb(1'h1, `SRR_ADDR_CFG, 32'h1);
    ahb(1'h1, `SRR_ADDR_PRESS, 32'h2010);
    ahb(1'h0, `SRR_ADDR_PRESS, 32'h0);
    check("press cfg", rd, 64'h2010);
    present <= 16'h2001;
    srr_host_model_i.xfer(8'h13, 1, rx);
    check("gate", gate, 4'h3);
    check("mode cont", mode, SRR_CONT);
    pulse(1'h0);
    check("press pin", {press_oe, press_o}, 2'h3);
    ahb(1'h0, `SRR_ADDR_STATUS, 32'h0);
    check("status reg", rd[9:0], 10'h18D);
    srr_host_model_i.xfer(8'h40, 5, rx);
    check("axis frame", rx[39:0], {8'h8D, 16'h1234, 16'h8102});
    srr_host_model_i.xfer(8'h80, 1, rx);
    // Angle frame on the Y-Z plane, all items then magnitude and T only
    ahb(1'h1, `SRR_ADDR_CFG, 32'hC);
    present <= 16'h2000;
    @(posedge SYS_CLK);
    check("plane select", aplane, 1'h1);
    srr_host_model_i.xfer(8'h3F, 1, rx);
    pulse(1'h0);
    srr_host_model_i.xfer(8'h40, 9, rx);
    check("angle frame", rx, {8'h01, 16'h1234, 16'h9030, 16'h4321,
                              16'h8005});
    srr_host_model_i.xfer(8'h35, 1, rx);
    pulse(1'h0);
    srr_host_model_i.xfer(8'h40, 5, rx);
    check("angle tb frame", rx[39:0], {8'h01, 16'h1234, 16'h4321});
    // Trigger pin starts a single conversion
    @(posedge SYS_CLK);
    press_i <= 1'h1;
    repeat (4) @(posedge SYS_CLK);
    press_i <= 1'h0;
    repeat (6) @(posedge SYS_CLK);
    check("trigger mode", mode, SRR_SINGLE);
    pulse(1'h0);
    check("idle after single", mode, SRR_IDLE);
    check("start pulses", n_start, 7);
    give_verdict();
  end
endmodule
